// ### hdl/ehp_cfg.svh
// Constants of the serial memory slave with pause support.
// Included by the package and the core; definitions only.
`ifndef EHP_CFG_SVH
`define EHP_CFG_SVH

// Density variant: 14 gives 16,384 bytes, 15 gives 32,768 bytes
`define EHP_ADDR_W     15
`define EHP_PAGE_W     6
`define EHP_WORD_W     8

// Opcodes
`define EHP_OP_WRSR    8'h01
`define EHP_OP_WRITE   8'h02
`define EHP_OP_READ    8'h03
`define EHP_OP_WRDI    8'h04
`define EHP_OP_RDSR    8'h05
`define EHP_OP_WREN    8'h06

// Bit counts within a phase (last rising edge index; read bits count falling edges)
`define EHP_CMD_LAST   4'h7
`define EHP_ADDR_LAST  4'hf
`define EHP_BYTE_LAST  4'h7
`define EHP_RBIT_LAST  3'h7

// Status byte field positions
`define EHP_STAT_RDY   0
`define EHP_STAT_WEL   1

// Reset values
`define EHP_SO_RST     1'b0
`define EHP_PIN_RST    4'hd

`endif

// ### hdl/ehp_core.sv
// Serial memory slave with pause, clocked by the system clock.
// Link pins arrive asynchronously; the serial clock is oversampled.
`default_nettype none
`include "ehp_cfg.svh"

// Behaviour
// - Pause freezes transfer state, resume continues it
// - Clock edges during pause have no effect
// - Paused: data input ignored, output floats
// - Array of 16,384 or 32,768 bytes
// - Deselected: no input taken, output floats
// - Capture on rising edge, shift on falling
module ehp_core
   import ehp_pkg::*;
(
   // System
   input  wire logic SYS_CLK,
   input  wire logic RESETN,
   // Link from master
   input  wire logic CS_N,
   input  wire logic SCK,
   input  wire logic SI,
   input  wire logic HOLD_N,
   // Serial data output pin
   output var  logic SO,
   output var  logic SO_OE
);

   localparam int AW = `EHP_ADDR_W;
   localparam int DEPTH = 1 << AW;

   // Agreement filter: a bit moves only when stages two and three match
   function automatic logic [3:0] ehp_filt(input logic [3:0] s2, input logic [3:0] s3,
                                           input logic [3:0] cur);
      ehp_filt = (s2 & s3) | (cur & (s2 ^ s3));
   endfunction

   ehp_pins_t  s1_r, s2_r, s3_r, f_r;
   logic       sck_prev_r;
   logic       sck_rise, sck_fall;
   logic       hold_r;
   ehp_state_t st_r;
   logic [3:0] cnt_r;
   logic [15:0] sr_r;
   logic [AW-1:0] addr_r;
   logic [7:0] out_byte_r;
   logic [2:0] rbit_r;
   logic       stat_mode_r;
   logic       rd_mode_r;
   logic       drv_r;
   logic       wel_r;
   logic       wr_seen_r;
   logic       act_rise, act_fall;
   logic [7:0] opcode;
   logic [15:0] addr_in;
   logic       cmd_done, wr_commit;
   logic [7:0] status;
   logic [7:0] mem [DEPTH];

   // Three-stage synchronisers on all link pins
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         s1_r       <= `EHP_PIN_RST;
         s2_r       <= `EHP_PIN_RST;
         s3_r       <= `EHP_PIN_RST;
         f_r        <= `EHP_PIN_RST;
         sck_prev_r <= 1'b1;
      end
      else
      begin
         s1_r       <= {CS_N, SCK, SI, HOLD_N};
         s2_r       <= s1_r;
         s3_r       <= s2_r;
         f_r        <= ehp_filt(s2_r, s3_r, f_r);
         sck_prev_r <= f_r.sck;
      end
   end

   assign sck_rise = f_r.sck & ~sck_prev_r;
   assign sck_fall = ~f_r.sck & sck_prev_r;
   // edges count only when selected and not paused
   assign act_rise = sck_rise & ~f_r.cs_n & ~hold_r;
   assign act_fall = sck_fall & ~f_r.cs_n & ~hold_r;
   assign opcode   = {sr_r[6:0], f_r.si};
   assign addr_in  = {sr_r[14:0], f_r.si};
   assign cmd_done = act_rise && st_r == ST_CMD && cnt_r == `EHP_CMD_LAST;
   assign wr_commit = act_rise && st_r == ST_WR && cnt_r == `EHP_BYTE_LAST;
   assign status   = {6'h00, wel_r, 1'b0};

   // Pause tracking; master keeps clock low at entry and exit
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
         hold_r <= 1'b0;
      else if (f_r.cs_n)
         hold_r <= 1'b0;
      else if (!hold_r && !f_r.hold_n && !f_r.sck)
         hold_r <= 1'b1;
      else if (hold_r && f_r.hold_n && !f_r.sck)
         hold_r <= 1'b0;
   end

   // Transfer engine
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_r        <= ST_CMD;
         cnt_r       <= 4'h0;
         sr_r        <= 16'h0000;
         addr_r      <= '0;
         out_byte_r  <= 8'h00;
         rbit_r      <= 3'h0;
         stat_mode_r <= 1'b0;
         rd_mode_r   <= 1'b0;
         drv_r       <= 1'b0;
         SO          <= `EHP_SO_RST;
      end
      else if (f_r.cs_n)
      begin
         st_r        <= ST_CMD;
         cnt_r       <= 4'h0;
         rbit_r      <= 3'h0;
         stat_mode_r <= 1'b0;
         drv_r       <= 1'b0;
      end
      else if (act_rise)
      begin
         sr_r  <= addr_in;
         cnt_r <= cnt_r + 4'h1;
         unique case (st_r)
            ST_CMD:
               if (cnt_r == `EHP_CMD_LAST)
               begin
                  cnt_r <= 4'h0;
                  rd_mode_r <= (opcode == `EHP_OP_READ);
                  if (opcode == `EHP_OP_READ || opcode == `EHP_OP_WRITE)
                     st_r <= ST_ADDR;
                  else if (opcode == `EHP_OP_RDSR)
                  begin
                     st_r        <= ST_RD;
                     stat_mode_r <= 1'b1;
                     out_byte_r  <= status;
                  end
                  else
                     st_r <= ST_IGN;
               end
            ST_ADDR:
               if (cnt_r == `EHP_ADDR_LAST)
               begin
                  cnt_r  <= 4'h0;
                  addr_r <= addr_in[AW-1:0];
                  if (rd_mode_r)
                  begin
                     st_r       <= ST_RD;
                     out_byte_r <= mem[addr_in[AW-1:0]];
                  end
                  // Writes without the enable latch are dropped
                  else
                     st_r <= wel_r ? ST_WR : ST_IGN;
               end
            ST_WR:
               if (cnt_r == `EHP_BYTE_LAST)
               begin
                  cnt_r  <= 4'h0;
                  // Wrap inside the page, as a page write does
                  addr_r <= {addr_r[AW-1:`EHP_PAGE_W],
                             addr_r[`EHP_PAGE_W-1:0] + 6'h01};
               end
            ST_RD, ST_IGN:
               cnt_r <= 4'h0;
         endcase
      end
      else if (act_fall && st_r == ST_RD)
      begin
         SO     <= out_byte_r[3'h7 - rbit_r];
         drv_r  <= 1'b1;
         rbit_r <= rbit_r + 3'h1;
         if (rbit_r == `EHP_RBIT_LAST)
         begin
            if (stat_mode_r)
               out_byte_r <= status;
            else
            begin
               addr_r     <= addr_r + 1'b1;
               out_byte_r <= mem[addr_r + 1'b1];
            end
         end
      end
   end

   // byte array sized by the density variant
   always_ff @(posedge SYS_CLK)
   begin
      if (wr_commit)
         mem[addr_r] <= addr_in[7:0];
   end

   // Write enable latch; cleared when a write frame that stored a byte ends
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         wel_r     <= 1'b0;
         wr_seen_r <= 1'b0;
      end
      else if (f_r.cs_n)
      begin
         if (wr_seen_r)
            wel_r <= 1'b0;
         wr_seen_r <= 1'b0;
      end
      else
      begin
         if (wr_commit)
            wr_seen_r <= 1'b1;
         if (cmd_done && opcode == `EHP_OP_WREN)
            wel_r <= 1'b1;
         else if (cmd_done && opcode == `EHP_OP_WRDI)
            wel_r <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
         SO_OE <= 1'b0;
      else
         SO_OE <= drv_r & ~hold_r & ~f_r.cs_n & (st_r == ST_RD);
   end

   // Checks
   logic [AW-1:0] wr_addr_q;
   logic [7:0]    wr_data_q;
   always_ff @(posedge SYS_CLK)
   begin
      wr_addr_q <= addr_r;
      wr_data_q <= addr_in[7:0];
   end

   a_hold_freeze: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (hold_r && !f_r.cs_n) |=> ($stable(st_r) && $stable(cnt_r) && $stable(addr_r)))
      else $error("state moved during pause");
   a_hold_edges: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (hold_r && sck_rise) |=> $stable(sr_r))
      else $error("clock edge taken during pause");
   a_hold_hiz: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      hold_r[*2] |-> !SO_OE)
      else $error("output driven during pause");
   a_desel_hiz: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      f_r.cs_n |=> (!SO_OE && st_r == ST_CMD && cnt_r == 4'h0))
      else $error("deselected slave not idle");
   a_capture_rise: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      act_rise |=> sr_r[0] == $past(f_r.si))
      else $error("data bit not captured on rise");
   a_so_fall: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      !$stable(SO) |-> $past(act_fall))
      else $error("output changed off a falling edge");
   a_desel_pause: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (hold_r && f_r.cs_n) |=> (!hold_r && st_r == ST_CMD))
      else $error("deselect did not abandon paused transfer");
   a_array_store: assert property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      wr_commit |=> mem[wr_addr_q] == wr_data_q)
      else $error("written byte not stored");

   c_pause_read: cover property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (st_r == ST_RD && drv_r) ##1 hold_r ##[1:400] !hold_r);
   c_pause_addr: cover property (
      @(posedge SYS_CLK) disable iff (!RESETN)
      (st_r == ST_ADDR && hold_r) ##[1:400] (st_r == ST_WR));
   c_write: cover property (
      @(posedge SYS_CLK) disable iff (!RESETN) wr_commit);
   c_desel_pause: cover property (
      @(posedge SYS_CLK) disable iff (!RESETN) hold_r && f_r.cs_n);
endmodule // ehp_core

`default_nettype wire

// ### hdl/ehp_pkg.sv
// Types shared by the pause-capable serial memory slave.
// Assumes ehp_cfg.svh sits beside it on the include path.
`default_nettype none
`include "ehp_cfg.svh"

package ehp_pkg;

   // Link pins as sampled by the system clock
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
   } ehp_pins_t;

   // Transfer phase; Gray along command, address, data
   typedef enum logic [2:0] {
      ST_CMD  = 3'b000,
      ST_ADDR = 3'b001,
      ST_WR   = 3'b011,
      ST_RD   = 3'b101,
      ST_IGN  = 3'b100
   } ehp_state_t;

endpackage

`default_nettype wire

// ### verification/ehp_master.sv
// Serial link master model for the pause-capable memory slave, mode 0.
// Assumes the bench resolves the slave output into so_w.
`default_nettype none

module ehp_master
(
   // System
   input  wire logic clk,
   input  wire logic so_w,
   // Link
   output var  logic cs_n,
   output var  logic sck,
   output var  logic si,
   output var  logic hold_n
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end

   // Half of the 160 ns link period
   task automatic hw();
      repeat (8) @(posedge clk);
   endtask

   task automatic sel(input logic v);
      @(posedge clk);
      cs_n <= v;
      hw();
   endtask

   // Output sampled late in the low phase, well after the fall
   task automatic bits(input int n, input logic [7:0] d, output logic [7:0] q);
      q = 8'h00;
      // Low and high phases of 8 cycles each, a 160 ns period
      for (int i = n - 1; i >= 0; i--)
      begin
         si <= d[i];
         repeat (7) @(posedge clk);
         @(negedge clk);
         q = {q[6:0], so_w};
         @(posedge clk);
         sck <= 1'b1;
         hw();
         sck <= 1'b0;
      end
   endtask

   // pause pin moved with clock low
   task automatic pause(input logic v);
      @(posedge clk);
      hold_n <= v;
      hw();
   endtask

   // Clock and data wiggle that the slave must not count
   task automatic wiggle(input int n);
      repeat (n)
      begin
         @(posedge clk);
         sck <= 1'b1;
         si <= ~si;
         hw();
         sck <= 1'b0;
         hw();
      end
   endtask
endmodule // ehp_master

`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the pause-capable serial memory slave.
// Assumes the design files under hdl/ and the master model are compiled first.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic      sys_clk = 1'b0;
   logic      resetn = 1'b0;
   wire logic cs_n;
   wire logic sck;
   wire logic si;
   wire logic hold_n;
   wire logic so;
   wire logic so_oe;
   wire logic so_w;
   int        fails = 0;
   int        checks = 0;
   int        cyc = 0;

   assign so_w = so_oe ? so : 1'bz;

   always #5 sys_clk = ~sys_clk;

   ehp_core dut_u (.SYS_CLK(sys_clk), .RESETN(resetn), .CS_N(cs_n), .SCK(sck),
                   .SI(si), .HOLD_N(hold_n), .SO(so), .SO_OE(so_oe));
   ehp_master m_u (.clk(sys_clk), .so_w(so_w), .cs_n(cs_n), .sck(sck), .si(si),
                   .hold_n(hold_n));

   task automatic results();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_oe(input string nm, input logic e);
      @(negedge sys_clk);
      checks++;
      if (so_oe !== e)
      begin
         fails++;
         $display("BAD %s expected %b seen %b", nm, e, so_oe);
      end
   endtask

   task automatic cmd(input logic [7:0] op, input logic [15:0] a);
      logic [7:0] q;
      m_u.sel(1'b0);
      m_u.bits(8, op, q);
      m_u.bits(8, a[15:8], q);
      m_u.bits(8, a[7:0], q);
   endtask

   task automatic wren();
      logic [7:0] q;
      m_u.sel(1'b0);
      m_u.bits(8, 8'h06, q);
      m_u.sel(1'b1);
   endtask

   task automatic rdsr(input logic [7:0] e);
      logic [7:0] q;
      m_u.sel(1'b0);
      m_u.bits(8, 8'h05, q);
      m_u.bits(8, 8'h00, q);
      m_u.sel(1'b1);
      chk("status", e, q);
   endtask

   task automatic t_write();
      logic [7:0] q;
      wren();
      rdsr(8'h02);
      cmd(8'h02, 16'h7fff);
      m_u.bits(8, 8'h5a, q);
      m_u.sel(1'b1);
      rdsr(8'h00);
      cmd(8'h03, 16'hffff);
      m_u.bits(8, 8'h00, q);
      m_u.sel(1'b1);
      chk("rd_top", 8'h5a, q);
   endtask

   task automatic t_pause();
      logic [7:0] h;
      logic [7:0] l;
      wren();
      cmd(8'h02, 16'h0010);
      m_u.bits(8, 8'h3c, h);
      m_u.bits(8, 8'hc3, h);
      m_u.sel(1'b1);
      cmd(8'h03, 16'h0010);
      m_u.bits(4, 8'h00, h);
      m_u.pause(1'b0);
      chk_oe("oe_pause", 1'b0);
      m_u.wiggle(3);
      chk_oe("oe_wiggle", 1'b0);
      m_u.pause(1'b1);
      m_u.bits(4, 8'h00, l);
      chk("rd_resume", 8'h3c, {h[3:0], l[3:0]});
      m_u.bits(8, 8'h00, l);
      chk("rd_next", 8'hc3, l);
      m_u.sel(1'b1);
   endtask

   task automatic t_guard();
      logic [7:0] q;
      wren();
      m_u.sel(1'b0);
      m_u.bits(8, 8'h04, q);
      m_u.sel(1'b1);
      rdsr(8'h00);
      cmd(8'h02, 16'h0010);
      m_u.bits(8, 8'h99, q);
      m_u.sel(1'b1);
      cmd(8'h03, 16'h0010);
      m_u.bits(8, 8'h00, q);
      m_u.sel(1'b1);
      chk("rd_locked", 8'h3c, q);
   endtask

   task automatic t_reset();
      logic [7:0] q;
      wren();
      cmd(8'h03, 16'h0010);
      m_u.bits(2, 8'h00, q);
      resetn <= 1'b0;
      m_u.sel(1'b1);
      resetn <= 1'b1;
      rdsr(8'h00);
   endtask

   task automatic t_abort();
      logic [7:0] h;
      cmd(8'h03, 16'h0010);
      m_u.bits(3, 8'h00, h);
      m_u.pause(1'b0);
      m_u.sel(1'b1);
      m_u.pause(1'b1);
      chk_oe("oe_desel", 1'b0);
      m_u.wiggle(2);
      chk_oe("oe_idle", 1'b0);
      rdsr(8'h00);
   endtask

   initial
   begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      t_write();
      t_pause();
      t_guard();
      t_abort();
      t_reset();
      results();
   end

   // Whole run needs well under this many cycles
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         results();
      end
   end
endmodule // tb_top

`default_nettype wire
